// file: design/rtc_spi_slave_register_port.sv
// serial register port with counter coherence and tick hold-off
`timescale 1ns/1ps
`default_nettype none
module rtc_spi_slave_register_port
#(
	parameter int HOLD_TIMEOUT = spi_port_pkg::HOLD_TIMEOUT_CYCLES
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic spi_clk,
	input wire logic chip_enable_n,
	input wire logic serial_in,
	output logic serial_out,
	output logic serial_out_oe_n,
	output logic [spi_port_pkg::ADDR_W-1:0] rd_addr,
	input wire logic [spi_port_pkg::DATA_W-1:0] rd_data,
	output logic wr_valid,
	input wire logic wr_ready,
	output logic [spi_port_pkg::ADDR_W-1:0] wr_addr,
	output logic [spi_port_pkg::DATA_W-1:0] wr_data,
	input wire logic counter_write_enable,
	input wire logic tick_1hz_in,
	input wire logic tick_100hz_in,
	output logic tick_1hz_out,
	output logic tick_100hz_out,
	output logic hold_ticks,
	output logic chain_reset
);
	////////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic sck_m;
		logic sck_s;
		logic sck_q;
		logic ce_m;
		logic ce_s;
		logic din_m;
		logic din_s;
		spi_port_pkg::phase_t phase;
		logic [2:0] bit_cnt;
		logic [spi_port_pkg::DATA_W-1:0] sh_in;
		logic [spi_port_pkg::DATA_W-1:0] sh_out;
		logic [spi_port_pkg::ADDR_W-1:0] ptr;
		logic load;
		logic so;
		logic so_oe_n;
		logic push_v;
		logic [spi_port_pkg::WORD_W-1:0] push_w;
		logic hold;
		logic [spi_port_pkg::TMO_W-1:0] tmo;
		logic pend1;
		logic pend100;
		logic tick1;
		logic tick100;
		logic chain_rst;
	} port_state_t;

	localparam logic [spi_port_pkg::TMO_W-1:0] TMO_LIMIT =
		spi_port_pkg::TMO_W'(HOLD_TIMEOUT - 1);

	logic rst_m_r;
	logic rst_s_r;
	port_state_t s_r;
	port_state_t s_nxt;
	logic rise;
	logic fall;
	logic [spi_port_pkg::DATA_W-1:0] byte_in;
	logic counter_hit;

	byte_stream_if wr_in ();
	byte_stream_if wr_out ();

	////////////////////////////////////////////////////////////////////////////
	// reset release through two flops

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_m_r <= 1'b0;
			rst_s_r <= 1'b0;
		end
		else
		begin
			rst_m_r <= 1'b1;
			rst_s_r <= rst_m_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// write path buffer, drained by the register file

	assign wr_in.valid = s_r.push_v;
	assign wr_in.word = s_r.push_w;

	word_buffer2 u_buf
	(
		.clk(clk),
		.rst_n(rst_s_r),
		.in_s(wr_in),
		.out_s(wr_out)
	);

	assign wr_valid = wr_out.valid;
	assign wr_out.ready = wr_ready;
	assign wr_addr = wr_out.word[spi_port_pkg::WORD_W-1:spi_port_pkg::DATA_W];
	assign wr_data = wr_out.word[spi_port_pkg::DATA_W-1:0];

	////////////////////////////////////////////////////////////////////////////
	// edges of the master clock, found after the synchronisers

	assign rise = s_r.sck_s && !s_r.sck_q;
	assign fall = !s_r.sck_s && s_r.sck_q;
	assign byte_in = {s_r.sh_in[spi_port_pkg::DATA_W-2:0], s_r.din_s};
	assign counter_hit = spi_port_pkg::is_counter(s_r.ptr);

	always_comb
	begin
		s_nxt = s_r;
		s_nxt.sck_m = spi_clk;
		s_nxt.sck_s = s_r.sck_m;
		s_nxt.sck_q = s_r.sck_s;
		s_nxt.ce_m = chip_enable_n;
		s_nxt.ce_s = s_r.ce_m;
		s_nxt.din_m = serial_in;
		s_nxt.din_s = s_r.din_m;
		s_nxt.load = 1'b0;
		s_nxt.chain_rst = 1'b0;
		s_nxt.tick1 = 1'b0;
		s_nxt.tick100 = 1'b0;

		// word stays offered until the buffer takes it
		if (s_r.push_v && wr_in.ready)
			s_nxt.push_v = 1'b0;

		if (s_r.ce_s)
		begin
			// frame over: drop partial byte, release the output line
			s_nxt.phase = spi_port_pkg::PH_ADDR;
			s_nxt.bit_cnt = 3'h0;
			s_nxt.so_oe_n = 1'b1;
			s_nxt.hold = 1'b0;
		end
		else
		begin
			if (rise)
			begin
				s_nxt.sh_in = byte_in;
				s_nxt.bit_cnt = s_r.bit_cnt + 3'h1;
				if (s_r.bit_cnt == spi_port_pkg::LAST_BIT)
				begin
					case (s_r.phase)
						spi_port_pkg::PH_ADDR:
						begin
							s_nxt.ptr = byte_in[spi_port_pkg::ADDR_W-1:0];
							if (byte_in[spi_port_pkg::RW_BIT])
								s_nxt.phase = spi_port_pkg::PH_WRITE;
							else
							begin
								s_nxt.phase = spi_port_pkg::PH_READ;
								s_nxt.load = 1'b1;
							end
							if (spi_port_pkg::is_counter(byte_in[spi_port_pkg::ADDR_W-1:0]))
								s_nxt.hold = 1'b1;
						end
						spi_port_pkg::PH_WRITE:
						begin
							// counter bytes without write enable are dropped
							if (!counter_hit || counter_write_enable)
							begin
								s_nxt.push_v = 1'b1;
								s_nxt.push_w = {s_r.ptr, byte_in};
							end
							if (counter_hit && counter_write_enable)
								s_nxt.chain_rst = 1'b1;
							s_nxt.ptr = s_r.ptr + spi_port_pkg::PTR_STEP;
							if (spi_port_pkg::is_counter(s_r.ptr + spi_port_pkg::PTR_STEP))
								s_nxt.hold = 1'b1;
						end
						spi_port_pkg::PH_READ:
							s_nxt.load = 1'b1;
						default:
							s_nxt.phase = spi_port_pkg::PH_ADDR;
					endcase
				end
			end

			// output changes only on falling edges, read phase only
			if (fall && s_r.phase == spi_port_pkg::PH_READ)
			begin
				s_nxt.so = s_r.sh_out[spi_port_pkg::DATA_W-1];
				s_nxt.sh_out = {s_r.sh_out[spi_port_pkg::DATA_W-2:0], 1'b0};
				s_nxt.so_oe_n = 1'b0;
			end

			// the pointed byte is fetched in the cycle after the last rise of a byte
			if (s_r.load)
			begin
				s_nxt.sh_out = rd_data;
				s_nxt.ptr = s_r.ptr + spi_port_pkg::PTR_STEP;
				if (spi_port_pkg::is_counter(s_r.ptr + spi_port_pkg::PTR_STEP))
					s_nxt.hold = 1'b1;
			end
		end

		// a stalled master must not freeze timekeeping for good
		if (s_r.hold)
		begin
			if (rise || fall)
				s_nxt.tmo = '0;
			else if (s_r.tmo == TMO_LIMIT)
			begin
				s_nxt.hold = 1'b0;
				s_nxt.tmo = '0;
			end
			else
				s_nxt.tmo = s_r.tmo + spi_port_pkg::TMO_W'(1);
		end
		else
			s_nxt.tmo = '0;

		// ticks are deferred while held; repeats merge into one pending tick
		if (s_r.hold)
		begin
			s_nxt.pend1 = s_r.pend1 || tick_1hz_in;
			s_nxt.pend100 = s_r.pend100 || tick_100hz_in;
		end
		else
		begin
			s_nxt.tick1 = tick_1hz_in || s_r.pend1;
			s_nxt.tick100 = tick_100hz_in || s_r.pend100;
			s_nxt.pend1 = 1'b0;
			s_nxt.pend100 = 1'b0;
		end

		// chain restart makes an old deferred tick stale
		if (s_r.chain_rst)
		begin
			s_nxt.pend1 = 1'b0;
			s_nxt.pend100 = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_s_r)
	begin
		if (!rst_s_r)
		begin
			s_r <= '0;
			s_r.sck_m <= 1'b0;
			s_r.ce_m <= 1'b1;
			s_r.ce_s <= 1'b1;
			s_r.so_oe_n <= 1'b1;
			s_r.phase <= spi_port_pkg::PH_ADDR;
		end
		else
			s_r <= s_nxt;
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs; a counter write may skew one square-wave period downstream

	assign serial_out = s_r.so;
	assign serial_out_oe_n = s_r.so_oe_n;
	assign rd_addr = s_r.ptr;
	assign hold_ticks = s_r.hold;
	assign chain_reset = s_r.chain_rst;
	assign tick_1hz_out = s_r.tick1;
	assign tick_100hz_out = s_r.tick100;
endmodule // rtc_spi_slave_register_port
`default_nettype wire

// file: design/word_buffer2.sv
// two-entry buffer between the serial side and the register write side
`timescale 1ns/1ps
`default_nettype none
module word_buffer2
(
	input wire logic clk,
	input wire logic rst_n,
	byte_stream_if.snk in_s,
	byte_stream_if.src out_s
);
	typedef struct packed {
		logic [spi_port_pkg::BUF_DEPTH-1:0][spi_port_pkg::WORD_W-1:0] mem;
		logic rd_idx;
		logic wr_idx;
		logic [1:0] count;
	} buf_state_t;

	buf_state_t s_r;
	buf_state_t s_nxt;
	logic push;
	logic pop;

	assign in_s.ready = (s_r.count != 2'(spi_port_pkg::BUF_DEPTH));
	assign out_s.valid = (s_r.count != 2'h0);
	assign out_s.word = s_r.mem[s_r.rd_idx];
	assign push = in_s.valid && in_s.ready;
	assign pop = out_s.valid && out_s.ready;

	always_comb
	begin
		s_nxt = s_r;
		if (push)
		begin
			s_nxt.mem[s_r.wr_idx] = in_s.word;
			s_nxt.wr_idx = ~s_r.wr_idx;
		end
		if (pop)
			s_nxt.rd_idx = ~s_r.rd_idx;
		if (push && !pop)
			s_nxt.count = s_r.count + 2'h1;
		else if (pop && !push)
			s_nxt.count = s_r.count - 2'h1;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end
endmodule // word_buffer2
`default_nettype wire

// file: shared/byte_stream_if.sv
// address and data word stream with valid and ready
`timescale 1ns/1ps
`default_nettype none
interface byte_stream_if;
	logic valid;
	logic ready;
	logic [spi_port_pkg::WORD_W-1:0] word;
	modport src (output valid, output word, input ready);
	modport snk (input valid, input word, output ready);
endinterface
`default_nettype wire

// file: shared/spi_port_pkg.sv
// constants and types shared by the serial register port
package spi_port_pkg;
	localparam int ADDR_W = 7;
	localparam int DATA_W = 8;
	localparam logic [2:0] LAST_BIT = 3'h7;
	localparam int RW_BIT = 7;
	localparam logic [ADDR_W-1:0] PTR_STEP = 7'h01;
	localparam logic [ADDR_W-1:0] COUNTER_FIRST = 7'h00;
	localparam logic [ADDR_W-1:0] COUNTER_LAST = 7'h07;
	localparam int CLK_HZ = 20000000;
	localparam int HOLD_TIMEOUT_MS = 250;
	localparam int HOLD_TIMEOUT_CYCLES = (CLK_HZ / 1000) * HOLD_TIMEOUT_MS;
	localparam int TMO_W = 24;
	localparam int BUF_DEPTH = 2;
	localparam int WORD_W = ADDR_W + DATA_W;

	typedef enum {PH_ADDR, PH_WRITE, PH_READ} phase_t;

	function automatic logic is_counter(input logic [ADDR_W-1:0] a);
		return (a >= COUNTER_FIRST) && (a <= COUNTER_LAST);
	endfunction
endpackage

// file: verification/rtc_spi_slave_register_port_tb_top.sv
// self-checking bench for the serial register port
`timescale 1ns/1ps
`default_nettype none
module rtc_spi_slave_register_port_tb_top;
	logic clk, rst_n, spi_clk, chip_enable_n, serial_in, serial_out, serial_out_oe_n;
	logic so_last, wr_valid, wr_ready, counter_write_enable, tick_in, hold_ticks, chain_reset;
	logic tick_1hz_out, tick_100hz_out;
	logic [6:0] rd_addr, wr_addr;
	logic [7:0] wr_data, rx, r0;
	logic [7:0] mem [128];
	int num_errors = 0;
	int checks = 0;
	int cyc = 0;
	int chains = 0;
	int ticks = 0;
	// released pin shows the inverse of its last driven level
	spi_master_model m_u (.spi_clk, .chip_enable_n, .serial_in,
		.miso(serial_out_oe_n ? ~so_last : serial_out), .oe_n(serial_out_oe_n));
	rtc_spi_slave_register_port #(.HOLD_TIMEOUT(200)) dut_u (.clk, .rst_n, .spi_clk,
		.chip_enable_n, .serial_in, .serial_out, .serial_out_oe_n, .rd_addr,
		.rd_data(mem[rd_addr]), .wr_valid, .wr_ready, .wr_addr, .wr_data,
		.counter_write_enable, .tick_1hz_in(tick_in), .tick_100hz_in(tick_in),
		.tick_1hz_out, .tick_100hz_out, .hold_ticks, .chain_reset);
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc++;
		if (serial_out_oe_n === 1'b0)
			so_last <= serial_out;
		if (wr_valid === 1'b1 && wr_ready === 1'b1)
			mem[wr_addr] <= wr_data;
		chains += chain_reset;
		ticks += tick_1hz_out && tick_100hz_out;
		if (cyc == 20000)
		begin
			num_errors++;
			finish_test();
		end
	end
	////////////////////////////////////////
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask
	task automatic fail(input string what);
		num_errors++;
		$display("unexpected at %0t: %s", $time, what);
	endtask
	task automatic finish_test();
		if (num_errors == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic t_write();
		counter_write_enable = 1'b1;
		wr_ready = 1'b0;
		m_u.sel();
		m_u.xfer(8'hFE, 8, rx);
		m_u.xfer(8'h11, 8, rx);
		m_u.xfer(8'h22, 8, rx);
		checks++;
		if (!(wr_valid === 1'b1 && mem[7'h7E] === 8'h00))
			fail("stall");
		wr_ready = 1'b1;
		#400;
		m_u.xfer(8'h33, 8, rx);
		m_u.desel();
		step(10);
		checks++;
		if (!(mem[7'h7E] === 8'h11 && mem[7'h7F] === 8'h22))
			fail("burst");
		checks++;
		if (!(mem[7'h00] === 8'h33 && chains === 1))
			fail("wrap");
		checks++;
		if (m_u.drove !== 0)
			fail("driven in write");
	endtask
	task automatic t_guard();
		counter_write_enable = 1'b0;
		chains = 0;
		m_u.sel();
		m_u.xfer(8'h87, 8, rx);
		m_u.xfer(8'h44, 8, rx);
		m_u.xfer(8'h55, 8, rx);
		m_u.desel();
		step(10);
		checks++;
		if (!(mem[7'h07] === 8'h00 && chains === 0))
			fail("guarded");
		checks++;
		if (mem[7'h08] !== 8'h55)
			fail("after guard");
	endtask
	task automatic t_read();
		mem[7'h7F] = 8'hA5;
		mem[7'h00] = 8'h3C;
		m_u.sel();
		m_u.xfer(8'h7F, 8, r0);
		m_u.xfer(8'h00, 8, r0);
		m_u.xfer(8'h00, 8, rx);
		tick_in = 1'b1;
		step(1);
		tick_in = 1'b0;
		checks++;
		if (!(hold_ticks === 1'b1 && ticks === 0))
			fail("not held");
		step(7);
		m_u.desel();
		step(4);
		checks++;
		if (!(r0 === 8'hA5 && rx === 8'h3C))
			fail("read data");
		checks++;
		if (!(ticks === 1 && hold_ticks === 1'b0))
			fail("deferred tick");
	endtask
	task automatic t_abort();
		m_u.sel();
		m_u.xfer(8'hFF, 4, rx);
		m_u.desel();
		step(2);
		m_u.sel();
		m_u.xfer(8'h90, 8, rx);
		m_u.xfer(8'h5A, 8, rx);
		m_u.desel();
		step(10);
		checks++;
		if (mem[7'h10] !== 8'h5A)
			fail("partial byte");
	endtask
	task automatic t_timeout();
		m_u.sel();
		m_u.xfer(8'h00, 8, rx);
		step(2);
		checks++;
		if (hold_ticks !== 1'b1)
			fail("no hold");
		// a tick while stalled must come out once the guard fires
		tick_in = 1'b1;
		step(1);
		tick_in = 1'b0;
		step(219);
		checks++;
		if (!(hold_ticks === 1'b0 && ticks === 2))
			fail("hold stuck");
		tick_in = 1'b1;
		step(1);
		tick_in = 1'b0;
		step(1);
		checks++;
		if (ticks !== 3)
			fail("tick not passed");
		m_u.desel();
		step(2);
	endtask
	task automatic t_reread();
		logic [7:0] h, s, h2, s2;
		mem[7'h00] = 8'h99;
		mem[7'h01] = 8'h12;
		m_u.sel();
		m_u.xfer(8'h00, 8, h);
		m_u.xfer(8'h00, 8, h);
		m_u.xfer(8'h00, 8, s);
		m_u.desel();
		// counters roll over between the two bursts
		mem[7'h00] = 8'h00;
		mem[7'h01] = 8'h13;
		h2 = h;
		s2 = s;
		if (h === 8'h00 || h === 8'h99)
		begin
			m_u.sel();
			m_u.xfer(8'h00, 8, h2);
			m_u.xfer(8'h00, 8, h2);
			m_u.xfer(8'h00, 8, s2);
			m_u.desel();
		end
		checks++;
		if (!(h === 8'h99 && s === 8'h12 && h2 === 8'h00 && s2 === 8'h13))
			fail("reread");
	endtask
	initial
	begin
		rst_n = 1'b0;
		wr_ready = 1'b1;
		counter_write_enable = 1'b0;
		tick_in = 1'b0;
		so_last = 1'b0;
		for (int i = 0; i < 128; i++)
			mem[i] = 8'h00;
		step(10);
		rst_n = 1'b1;
		step(6);
		t_write();
		t_guard();
		t_read();
		t_abort();
		t_timeout();
		t_reread();
		finish_test();
	end
endmodule // rtc_spi_slave_register_port_tb_top
`default_nettype wire

// file: verification/spi_master_model.sv
// serial master model, clock idle low, sample on rise
`timescale 1ns/1ps
`default_nettype none
module spi_master_model
(
	output logic spi_clk,
	output logic chip_enable_n,
	output logic serial_in,
	input wire logic miso,
	input wire logic oe_n
);
	int drove = 0;
	initial
	begin
		spi_clk = 1'b0;
		chip_enable_n = 1'b1;
		serial_in = 1'b0;
	end
	// 400 ns per bit; clock stands low between bytes
	task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
		for (int i = 7; i > 7 - n; i--)
		begin
			serial_in = tx[i];
			#200;
			spi_clk = 1'b1;
			rx[i] = miso;
			drove += !oe_n;
			#200;
			spi_clk = 1'b0;
		end
	endtask
	task automatic sel();
		chip_enable_n = 1'b0;
		#350;
	endtask
	task automatic desel();
		#200;
		chip_enable_n = 1'b1;
		serial_in = ~serial_in;
		#400;
	endtask
endmodule // spi_master_model
`default_nettype wire

// file: verification/spi_port_props.sv
// pin-level assertions for the serial register port
`timescale 1ns/1ps
`default_nettype none
module spi_port_props
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic spi_clk,
	input wire logic chip_enable_n,
	input wire logic serial_out,
	input wire logic serial_out_oe_n,
	input wire logic wr_valid,
	input wire logic wr_ready,
	input wire logic [7:0] wr_data,
	input wire logic counter_write_enable,
	input wire logic tick_1hz_in,
	input wire logic tick_1hz_out,
	input wire logic hold_ticks,
	input wire logic chain_reset
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	AST_OE_IDLE: assert property (chip_enable_n [*5] |-> serial_out_oe_n)
		else $error("pin driven while idle");
	AST_OE_FRAME: assert property ($fell(serial_out_oe_n) |-> !chip_enable_n)
		else $error("drive outside frame");
	AST_SO_STABLE: assert property (!serial_out_oe_n && spi_clk && $past(spi_clk)
		&& $past(spi_clk, 2) |-> $stable(serial_out))
		else $error("output moved in high half");
	AST_WV_HOLD: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_data))
		else $error("write word lost");
	AST_TICK_PASS: assert property (tick_1hz_in && !hold_ticks |=> tick_1hz_out)
		else $error("tick not passed");
	AST_TICK_HELD: assert property (hold_ticks && $past(hold_ticks) |-> !tick_1hz_out)
		else $error("tick while held");
	AST_CHAIN_PULSE: assert property (chain_reset |=> !chain_reset)
		else $error("long chain reset");
	AST_CHAIN_WE: assert property (chain_reset |-> $past(counter_write_enable))
		else $error("chain reset unguarded");
endmodule // spi_port_props
bind rtc_spi_slave_register_port spi_port_props props_u (.clk, .rst_n, .spi_clk,
	.chip_enable_n, .serial_out, .serial_out_oe_n, .wr_valid, .wr_ready, .wr_data,
	.counter_write_enable, .tick_1hz_in, .tick_1hz_out, .hold_ticks, .chain_reset);
`default_nettype wire
